// >>> core/adccfg_pkg.sv
package adccfg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADCCFG_NUM_REGS = 4;
  localparam int unsigned ADCCFG_ADDR_W = 2;
  localparam int unsigned ADCCFG_DATA_W = 8;
  localparam logic [1:0] ADDR_INPUT_GAIN = 2'h0;
  localparam logic [1:0] ADDR_RATE_MODE = 2'h1;
  localparam logic [1:0] ADDR_REF_FILTER = 2'h2;
  localparam logic [1:0] ADDR_CURRENT_ROUTE = 2'h3;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned INPUT_SELECT_LSB = 4;
  localparam int unsigned GAIN_LSB = 1;
  localparam int unsigned AMP_BYPASS_BIT = 0;
  localparam int unsigned RATE_CODE_LSB = 5;
  localparam int unsigned OP_MODE_LSB = 3;
  localparam int unsigned CONT_BIT = 2;
  localparam int unsigned TEMP_BIT = 1;
  localparam int unsigned BURNOUT_BIT = 0;
  localparam int unsigned REF_SEL_LSB = 6;
  localparam int unsigned LINE_FILT_LSB = 4;
  localparam int unsigned SWITCH_AUTO_BIT = 3;
  localparam int unsigned EXC_CODE_LSB = 0;
  localparam int unsigned ROUTE_ONE_LSB = 5;
  localparam int unsigned ROUTE_TWO_LSB = 2;
  localparam int unsigned READY_MODE_BIT = 1;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_DUTY = 2'h1;
  localparam logic [1:0] MODE_TURBO = 2'h2;
  localparam logic [2:0] RATE_RESERVED = 3'h7;
  localparam logic [2:0] ROUTE_RESERVED = 3'h7;
  localparam logic [3:0] INPUT_RESERVED = 4'hf;
  localparam logic [2:0] GAIN_FIRST_AMP_ONLY = 3'h3;
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] FILT_NONE = 2'h0;

  // ****************************************************************
  // Conversion periods in converter clock ticks at the nominal clock, and excitation currents in microamps
  // ****************************************************************
  localparam int unsigned PERIOD_W = 20;
  localparam logic [19:0] PERIOD_NORMAL [7] = '{20'h32000, 20'h1638e, 20'h0b1c7,
    20'h05b6d, 20'h0307c, 20'h01aaa, 20'h01000};
  localparam logic [10:0] EXC_UA [8] = '{11'h000, 11'h000, 11'h032, 11'h064,
    11'h0fa, 11'h1f4, 11'h3e8, 11'h5dc};

  function automatic logic [19:0] adccfg_period(input logic [2:0] rate,
                                                input logic [1:0] mode);
    logic [19:0] base;
    base = (rate == RATE_RESERVED) ? 20'h00000 : PERIOD_NORMAL[rate];
    case (mode)
      MODE_NORMAL: adccfg_period = base;
      MODE_DUTY: adccfg_period = {base[17:0], 2'b00};
      MODE_TURBO: adccfg_period = {1'b0, base[19:1]};
      default: adccfg_period = 20'h00000;
    endcase
  endfunction

endpackage

// >>> core/adccfg_field_decode.sv
`timescale 1ns/10ps
module adccfg_field_decode
  import adccfg_pkg::*;
(
  // Stored configuration
  input wire logic [7:0] cfg0,
  input wire logic [7:0] cfg1,
  input wire logic [7:0] cfg2,
  input wire logic [7:0] cfg3,
  // Effective controls
  output logic [3:0] input_select,
  output logic input_reserved,
  output logic [2:0] gain_code,
  output logic amp_enable,
  output logic [1:0] ref_select,
  output logic [1:0] line_filter,
  output logic [10:0] exc_current_ua,
  output logic [2:0] route_one,
  output logic [2:0] route_two
);

  logic temp_on;
  logic [2:0] rate;
  logic [1:0] mode;
  logic [2:0] exc;

  always_comb
  begin
    temp_on = cfg1[TEMP_BIT];
    rate = cfg1[RATE_CODE_LSB +: 3];
    mode = cfg1[OP_MODE_LSB +: 2];
    exc = cfg2[EXC_CODE_LSB +: 3];
    // Temperature mode overrides every input and gain setting.
    input_select = temp_on ? 4'h0 : cfg0[INPUT_SELECT_LSB +: 4];
    input_reserved = !temp_on && (input_select == INPUT_RESERVED);
    gain_code = temp_on ? 3'h0 : cfg0[GAIN_LSB +: 3];
    // The amplifier can only be bypassed at gains of one, two and four.
    amp_enable = temp_on || !cfg0[AMP_BYPASS_BIT] || (gain_code >= GAIN_FIRST_AMP_ONLY);
    ref_select = temp_on ? REF_INTERNAL : cfg2[REF_SEL_LSB +: 2];
    // Line rejection only exists at the slowest normal and duty rates.
    if ((rate == 3'h0) && ((mode == MODE_NORMAL) || (mode == MODE_DUTY)))
    begin
      line_filter = cfg2[LINE_FILT_LSB +: 2];
    end
    else
    begin
      line_filter = FILT_NONE;
    end
    exc_current_ua = EXC_UA[exc];
    route_one = (cfg3[ROUTE_ONE_LSB +: 3] == ROUTE_RESERVED) ? 3'h0
                : cfg3[ROUTE_ONE_LSB +: 3];
    route_two = (cfg3[ROUTE_TWO_LSB +: 3] == ROUTE_RESERVED) ? 3'h0
                : cfg3[ROUTE_TWO_LSB +: 3];
  end

endmodule

// >>> core/adccfg_rate_timer.sv
`timescale 1ns/10ps
module adccfg_rate_timer
  import adccfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic conv_tick,
  input wire logic run,
  input wire logic [19:0] period,
  // Result
  output logic data_tick
);

  logic [19:0] cnt_r;
  logic [19:0] cnt_nxt;
  logic [19:0] per_r;
  logic [19:0] per_nxt;
  logic tick_r;
  logic tick_nxt;

  // A new period is taken only between conversions, so a write never
  // shortens or stretches a conversion already in progress.
  always_comb
  begin
    cnt_nxt = cnt_r;
    per_nxt = per_r;
    tick_nxt = 1'b0;
    if (!run || (per_r == 20'h00000))
    begin
      cnt_nxt = 20'h00000;
      per_nxt = period;
    end
    else if (conv_tick)
    begin
      if (cnt_r >= per_r - 20'h00001)
      begin
        cnt_nxt = 20'h00000;
        per_nxt = period;
        tick_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 20'h00001;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 20'h00000;
      per_r <= 20'h00000;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      per_r <= per_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign data_tick = tick_r;

endmodule

// >>> core/adccfg_regbank.sv
`timescale 1ns/10ps
// Overview of operation
// - Four eight-bit registers, read and written by register commands.
// - Reset clears every register bit to zero.
// - Sleep leaves register contents untouched.
// - Writes accepted anytime; running conversion periods are not disturbed.
// - Register 0 holds input select, gain code and amplifier bypass.
// - Input select picks pairs, single-ended, monitors, short; 1111 reserved.
// - Gain equals two to the power of the gain code.
// - Bypass works only at gains one, two, four.
// - Register 1 holds rate, mode, continuous, temperature and burnout bits.
// - Mode 00 normal, 01 duty cycle, 10 turbo, 11 reserved.
// - Rate codes 000 to 110 give mode rates; 111 reserved.
// - Output rate scales with the converter clock frequency.
// - Continuous bit zero is single-shot, one is continuous.
// - Temperature mode uses internal reference and ignores register 0.
// - Burnout bit connects the sensor-fault current source.
// - Reference select: internal, dedicated pins, shared pins, supply.
// - Line rejection only at slowest normal or duty rate.
// - Auto switch closes on start and opens on sleep.
// - Excitation code selects off, reserved, or fixed currents.
// - Route fields: 000 off, 001-110 pins, 111 reserved.
// - Ready mode bit adds readiness on the shared data pin.
module adccfg_regbank
  import adccfg_pkg::*;
#(
  parameter int unsigned RATE_SCALE_SHIFT = 0
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register commands
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // Converter commands and timing
  input wire logic start_sync_cmd,
  input wire logic sleep_command,
  input wire logic conv_tick,
  // Conversion control
  output logic conv_active,
  output logic asleep,
  output logic data_tick,
  output logic continuous_conversion_flag,
  output logic [1:0] op_mode,
  // Analog front-end control
  output logic [3:0] input_select,
  output logic input_reserved,
  output logic [2:0] gain_code,
  output logic amp_enable,
  output logic temp_sensor_enable,
  output logic burnout_source_enable,
  output logic [1:0] ref_select,
  output logic [1:0] line_filter,
  output logic low_side_switch_closed,
  output logic [10:0] exc_current_ua,
  output logic [2:0] source_one_route,
  output logic [2:0] source_two_route,
  output logic ready_on_shared_pin
);

  // ****************************************************************
  // Register storage and read path
  // ****************************************************************
  logic [7:0] cfg_r [ADCCFG_NUM_REGS];
  logic [7:0] cfg_nxt [ADCCFG_NUM_REGS];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] cfg_flat;

  // A read in the same cycle as a write to that register sees the old value.
  always_comb
  begin
    for (int i = 0; i < ADCCFG_NUM_REGS; i++)
    begin
      cfg_nxt[i] = cfg_r[i];
    end
    if (reg_wr_stb)
    begin
      cfg_nxt[reg_addr] = reg_wdata;
    end
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_rd_stb;
    if (reg_rd_stb)
    begin
      rdata_nxt = cfg_r[reg_addr];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < ADCCFG_NUM_REGS; i++)
      begin
        cfg_r[i] <= CFG_RESET;
      end
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < ADCCFG_NUM_REGS; i++)
      begin
        cfg_r[i] <= cfg_nxt[i];
      end
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign cfg_flat = {cfg_r[3], cfg_r[2], cfg_r[1], cfg_r[0]};

  // ****************************************************************
  // Field decode
  // ****************************************************************
  logic [3:0] dec_input;
  logic dec_input_res;
  logic [2:0] dec_gain;
  logic dec_amp;
  logic [1:0] dec_ref;
  logic [1:0] dec_filt;
  logic [10:0] dec_exc;
  logic [2:0] dec_r1;
  logic [2:0] dec_r2;

  adccfg_field_decode u_decode (
    .cfg0(cfg_r[0]),
    .cfg1(cfg_r[1]),
    .cfg2(cfg_r[2]),
    .cfg3(cfg_r[3]),
    .input_select(dec_input),
    .input_reserved(dec_input_res),
    .gain_code(dec_gain),
    .amp_enable(dec_amp),
    .ref_select(dec_ref),
    .line_filter(dec_filt),
    .exc_current_ua(dec_exc),
    .route_one(dec_r1),
    .route_two(dec_r2)
  );

  // ****************************************************************
  // Conversion control and low-side switch
  // ****************************************************************
  logic [19:0] period;
  logic tick;
  logic active_r;
  logic active_nxt;
  logic sleep_r;
  logic sleep_nxt;
  logic sw_r;
  logic sw_nxt;
  logic cont;
  logic sw_auto;

  assign cont = cfg_r[1][CONT_BIT];
  assign sw_auto = cfg_r[2][SWITCH_AUTO_BIT];
  assign period = adccfg_period(cfg_r[1][RATE_CODE_LSB +: 3],
                                cfg_r[1][OP_MODE_LSB +: 2]) >> RATE_SCALE_SHIFT;

  adccfg_rate_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .conv_tick(conv_tick),
    .run(active_r),
    .period(period),
    .data_tick(tick)
  );

  always_comb
  begin
    active_nxt = active_r;
    sleep_nxt = sleep_r;
    sw_nxt = sw_r;
    if (tick && !cont)
    begin
      active_nxt = 1'b0;
    end
    if (start_sync_cmd)
    begin
      active_nxt = 1'b1;
      sleep_nxt = 1'b0;
      sw_nxt = sw_auto;
    end
    if (sleep_command)
    begin
      active_nxt = 1'b0;
      sleep_nxt = 1'b1;
      sw_nxt = 1'b0;
    end
    if (!sw_auto)
    begin
      sw_nxt = 1'b0;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      active_r <= 1'b0;
      sleep_r <= 1'b0;
      sw_r <= 1'b0;
      data_tick <= 1'b0;
      continuous_conversion_flag <= 1'b0;
      op_mode <= 2'h0;
      input_select <= 4'h0;
      input_reserved <= 1'b0;
      gain_code <= 3'h0;
      amp_enable <= 1'b1;
      temp_sensor_enable <= 1'b0;
      burnout_source_enable <= 1'b0;
      ref_select <= 2'h0;
      line_filter <= 2'h0;
      exc_current_ua <= 11'h000;
      source_one_route <= 3'h0;
      source_two_route <= 3'h0;
      ready_on_shared_pin <= 1'b0;
    end
    else
    begin
      active_r <= active_nxt;
      sleep_r <= sleep_nxt;
      sw_r <= sw_nxt;
      data_tick <= tick;
      continuous_conversion_flag <= cont;
      op_mode <= cfg_r[1][OP_MODE_LSB +: 2];
      input_select <= dec_input;
      input_reserved <= dec_input_res;
      gain_code <= dec_gain;
      amp_enable <= dec_amp;
      temp_sensor_enable <= cfg_r[1][TEMP_BIT];
      burnout_source_enable <= cfg_r[1][BURNOUT_BIT];
      ref_select <= dec_ref;
      line_filter <= dec_filt;
      exc_current_ua <= dec_exc;
      source_one_route <= dec_r1;
      source_two_route <= dec_r2;
      ready_on_shared_pin <= cfg_r[3][READY_MODE_BIT];
    end
  end

  assign conv_active = active_r;
  assign asleep = sleep_r;
  assign low_side_switch_closed = sw_r;
  assign reg_rdata = rdata_r;
  assign reg_rd_valid = rvalid_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_reset_zero;
    @(posedge ref_clk) rst |-> (cfg_flat == 32'h00000000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("registers not cleared");

  property p_write_stores;
    @(posedge ref_clk) disable iff (rst)
      reg_wr_stb |=> (cfg_r[$past(reg_addr)] == $past(reg_wdata));
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("write lost");

  property p_read_back;
    @(posedge ref_clk) disable iff (rst)
      (reg_rd_stb && !reg_wr_stb) ##1 !reg_wr_stb |->
        reg_rd_valid && (reg_rdata == cfg_r[$past(reg_addr)]);
  endproperty
  a_read_back: assert property (p_read_back) else $error("read mismatch");

  property p_sleep_keeps;
    @(posedge ref_clk) disable iff (rst)
      (sleep_r && !reg_wr_stb) |=> $stable(cfg_flat);
  endproperty
  a_sleep_keeps: assert property (p_sleep_keeps) else $error("sleep changed regs");

  property p_amp_forced;
    @(posedge ref_clk) disable iff (rst)
      (cfg_r[0][GAIN_LSB +: 3] >= GAIN_FIRST_AMP_ONLY) && !reg_wr_stb |=> amp_enable;
  endproperty
  a_amp_forced: assert property (p_amp_forced) else $error("amp bypassed at high gain");

  property p_temp_override;
    @(posedge ref_clk) disable iff (rst)
      cfg_r[1][TEMP_BIT] |=> (ref_select == REF_INTERNAL) && (gain_code == 3'h0);
  endproperty
  a_temp_override: assert property (p_temp_override) else $error("temp mode leak");

  property p_filter_gate;
    @(posedge ref_clk) disable iff (rst)
      (cfg_r[1][RATE_CODE_LSB +: 3] != 3'h0) |=> (line_filter == FILT_NONE);
  endproperty
  a_filter_gate: assert property (p_filter_gate) else $error("filter at wrong rate");

  property p_switch_sleep;
    @(posedge ref_clk) disable iff (rst)
      sleep_command |=> !low_side_switch_closed ##1 !low_side_switch_closed || start_sync_cmd;
  endproperty
  a_switch_sleep: assert property (p_switch_sleep) else $error("switch closed in sleep");

  property p_switch_start;
    @(posedge ref_clk) disable iff (rst)
      start_sync_cmd && !sleep_command && sw_auto |=> low_side_switch_closed;
  endproperty
  a_switch_start: assert property (p_switch_start) else $error("switch not closed");

  property p_single_shot;
    @(posedge ref_clk) disable iff (rst)
      tick && !cont && !start_sync_cmd |=> !conv_active;
  endproperty
  a_single_shot: assert property (p_single_shot) else $error("single shot kept running");

  property p_ready_mode;
    @(posedge ref_clk) disable iff (rst)
      1'b1 |=> ready_on_shared_pin == $past(cfg_r[3][READY_MODE_BIT]);
  endproperty
  a_ready_mode: assert property (p_ready_mode) else $error("ready mode wrong");

endmodule

// >>> sim/adccfg_host_model.sv
`timescale 1ns/10ps
module adccfg_host_model
  import adccfg_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Register commands
  output logic reg_wr_stb,
  output logic reg_rd_stb,
  output logic [1:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  // Converter commands
  output logic start_sync_cmd,
  output logic sleep_command
);
  logic [7:0] rate_shadow;

  initial
  begin
    reg_wr_stb = 1'b0;
    reg_rd_stb = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    start_sync_cmd = 1'b0;
    sleep_command = 1'b0;
    rate_shadow = CFG_RESET;
  end

  // ****************************************************************
  // Register access
  // ****************************************************************
  // Released lines show the inverse so a stale value is never read.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ADDR_INPUT_GAIN && v[7:6] == 2'b10)
    begin
      v[0] = 1'b1;
      if (v[3:1] > 3'h2) v[3:1] = 3'h2;
    end
    if (a == ADDR_RATE_MODE) rate_shadow = v;
    if (a == ADDR_REF_FILTER && !(rate_shadow[7:5] == 3'h0 && rate_shadow[4:3] < 2'h2))
      v[5:4] = 2'h0;
    if (a == ADDR_CURRENT_ROUTE) v[0] = 1'b0;
    @(negedge ref_clk);
    reg_wr_stb = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge ref_clk);
    @(negedge ref_clk);
    reg_wr_stb = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge ref_clk);
    reg_rd_stb = 1'b1;
    reg_addr = a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    reg_rd_stb = 1'b0;
    reg_addr = ~reg_addr;
    for (int i = 0; i < 3 && ok !== 1'b1; i++)
    begin
      if (reg_rd_valid === 1'b1)
      begin
        d = reg_rdata;
        ok = 1'b1;
      end
      else
        @(negedge ref_clk);
    end
  endtask

  task automatic cmd(input logic start, input logic sleep);
    @(negedge ref_clk);
    start_sync_cmd = start;
    sleep_command = sleep;
    @(posedge ref_clk);
    @(negedge ref_clk);
    start_sync_cmd = 1'b0;
    sleep_command = 1'b0;
  endtask
endmodule

// >>> sim/adc_config_register_bank_bench.sv
`timescale 1ns/10ps
module adc_config_register_bank_bench
  import adccfg_pkg::*;
;
  logic ref_clk, rst, conv_tick, reg_wr_stb, reg_rd_stb, start_sync_cmd, sleep_command;
  logic [1:0] reg_addr, op_mode, ref_select, line_filter;
  logic [7:0] reg_wdata, reg_rdata;
  logic reg_rd_valid, conv_active, asleep, data_tick, cont, in_res, amp, temp, burn, sw, rdy;
  logic [3:0] in_sel;
  logic [2:0] gain, route1, route2;
  logic [10:0] exc;
  int fails = 0;
  int tests_run = 0;
  int tick_div = 0;
  int tick_phase = 0;
  int exc_exp [8] = '{0, 0, 50, 100, 250, 500, 1000, 1500};

  adccfg_regbank #(.RATE_SCALE_SHIFT(8)) adccfg_regbank_inst (.ref_clk(ref_clk), .rst(rst),
    .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .start_sync_cmd(start_sync_cmd), .sleep_command(sleep_command), .conv_tick(conv_tick),
    .conv_active(conv_active), .asleep(asleep), .data_tick(data_tick),
    .continuous_conversion_flag(cont), .op_mode(op_mode), .input_select(in_sel),
    .input_reserved(in_res), .gain_code(gain), .amp_enable(amp), .temp_sensor_enable(temp),
    .burnout_source_enable(burn), .ref_select(ref_select), .line_filter(line_filter),
    .low_side_switch_closed(sw), .exc_current_ua(exc), .source_one_route(route1),
    .source_two_route(route2), .ready_on_shared_pin(rdy));

  adccfg_host_model adccfg_host_model_inst (.ref_clk(ref_clk), .reg_wr_stb(reg_wr_stb),
    .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .start_sync_cmd(start_sync_cmd),
    .sleep_command(sleep_command));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    adccfg_host_model_inst.wr(a, d);
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    adccfg_host_model_inst.rd(a, d, ok);
    check("read valid", ok, 1);
    check("read data", d, exp);
  endtask

  // Waits for the next new-data pulse and returns the cycles spent.
  task automatic wait_data(output int n);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
      if (n > 2000)
      begin
        check("data_tick timeout", 0, 1);
        give_verdict();
      end
    end
    while (data_tick !== 1'b1);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    for (int a = 0; a < 4; a++)
      rdchk(a[1:0], 8'h00);
    check("amp_enable", amp, 1);
    check("route", {route1, route2, exc}, 0);
    $display("reset test done");
  endtask

  task automatic t_fields();
    wr(2'h0, 8'h5a);
    wr(2'h1, 8'h4d);
    wr(2'h2, 8'h87);
    wr(2'h3, 8'he6);
    check("input", {in_sel, gain, amp}, {4'h5, 3'h5, 1'b1});
    check("reg1", {op_mode, cont, temp, burn}, {2'h1, 1'b1, 1'b0, 1'b1});
    check("reg3", {route1, route2, rdy}, {3'h0, 3'h1, 1'b1});
    rdchk(2'h0, 8'h5a);
    rdchk(2'h1, 8'h4d);
    rdchk(2'h2, 8'h87);
    rdchk(2'h3, 8'he6);
    for (int i = 0; i < 8; i++)
    begin
      wr(2'h2, {i[1:0], 3'h0, i[2:0]});
      check("exc", exc, exc_exp[i]);
      check("ref", ref_select, i[1:0]);
    end
    wr(2'h0, 8'hf0);
    check("reserved input", in_res, 1);
    rdchk(2'h0, 8'hf0);
    $display("field test done");
  endtask

  task automatic t_gain();
    for (int g = 0; g < 8; g++)
    begin
      wr(2'h0, {1'b0, g[2:0], g[2:0], 1'b1});
      check("gain", gain, g);
      check("amp bypass", amp, g >= 3);
      check("input select", in_sel, g);
    end
    $display("gain test done");
  endtask

  task automatic t_temp_filter();
    wr(2'h2, 8'hc0);
    wr(2'h0, 8'h5e);
    wr(2'h1, 8'h02);
    check("temp", {temp, in_sel, gain, amp, ref_select}, {1'b1, 4'h0, 3'h0, 1'b1, 2'h0});
    wr(2'h1, 8'h00);
    for (int f = 1; f < 4; f++)
    begin
      wr(2'h2, {2'h0, f[1:0], 4'h0});
      check("filter", line_filter, f);
    end
    wr(2'h1, 8'h08);
    wr(2'h2, 8'h20);
    check("filter duty", line_filter, 2);
    $display("temp and filter test done");
  endtask

  task automatic t_conv();
    int n;
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h08);
    tick_div = 1;
    adccfg_host_model_inst.cmd(1'b1, 1'b0);
    check("active", {conv_active, sw}, 2'h3);
    wr(2'h0, 8'h12);
    wait_data(n);
    check("single period", n >= 790 && n <= 806, 1);
    check("single stop", conv_active, 0);
    wr(2'h1, 8'hd4);
    adccfg_host_model_inst.cmd(1'b1, 1'b0);
    wait_data(n);
    wait_data(n);
    check("turbo period", n >= 8 && n <= 9, 1);
    check("continuous", conv_active, 1);
    // Halving the converter clock must double the output period.
    tick_div = 2;
    wait_data(n);
    wait_data(n);
    check("half tick period", n >= 16 && n <= 17, 1);
    tick_div = 1;
    adccfg_host_model_inst.cmd(1'b0, 1'b1);
    check("sleep", {asleep, sw, conv_active}, 3'h4);
    rdchk(2'h1, 8'hd4);
    rdchk(2'h2, 8'h08);
    wr(2'h1, 8'he4);
    adccfg_host_model_inst.cmd(1'b1, 1'b0);
    n = 0;
    repeat (40) @(negedge ref_clk) n += data_tick;
    check("reserved rate", n, 0);
    $display("conversion test done");
  endtask

  // A reset in mid-run must clear registers that were written.
  task automatic t_mid_reset();
    wr(2'h3, 8'ha6);
    check("ready before reset", rdy, 1);
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    check("mid reset", {conv_active, asleep, sw, rdy}, 0);
    for (int a = 0; a < 4; a++)
      rdchk(a[1:0], 8'h00);
    $display("mid reset test done");
  endtask

  // ****************************************************************
  // Clock and main sequence
  // ****************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Converter ticks come every tick_div-th cycle, and none while it is 0.
  always @(negedge ref_clk)
  begin
    tick_phase = (tick_phase + 1 >= tick_div) ? 0 : tick_phase + 1;
    conv_tick = (tick_div != 0) && (tick_phase == 0);
  end

  initial
  begin
    rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_fields();
    t_gain();
    t_temp_filter();
    t_conv();
    t_mid_reset();
    give_verdict();
  end
endmodule
